// >>> src/ssr_select.sv
/*
  speed step and run select: decodes contact inputs into a speed reference
  and a run/direction command from the selected source.
  assumes contact inputs are asynchronous, parameters are static per operation,
  serial and option commands arrive already on this clock.
*/
`default_nettype none
module ssr_select #(
  parameter int HOLD_CYC = ssr_pkg::HOLD_CYCLES,
  parameter int SPD_W    = ssr_pkg::SPEED_W
) (
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  input  wire logic                          forward_run_input,
  input  wire logic                          reverse_run_input,
  input  wire logic [ssr_pkg::NUM_PROG-1:0]  prog_input,
  input  wire logic [ssr_pkg::NUM_PROG*8-1:0] input_function_params,
  input  wire logic                          initialize_three_wire,
  input  wire logic [0:0]                    speed_source_select,
  input  wire logic [1:0]                    run_source_select,
  input  wire logic [7:0]                    second_analog_function,
  input  wire logic [7:0]                    third_analog_function,
  input  wire logic [SPD_W*ssr_pkg::NUM_PRESETS-1:0] preset_speeds,
  input  wire logic [SPD_W-1:0]              jog_preset_speed,
  input  wire logic [SPD_W-1:0]              analog_in_first,
  input  wire logic [SPD_W-1:0]              analog_in_second,
  input  wire logic [SPD_W-1:0]              analog_in_third,
  input  wire ssr_pkg::ssr_cmd_t             operator_cmd,
  input  wire ssr_pkg::ssr_cmd_t             serial_cmd,
  input  wire ssr_pkg::ssr_cmd_t             option_cmd,
  output logic [SPD_W-1:0]                   speed_ref,
  output logic [4:0]                         speed_index,
  output ssr_pkg::ssr_ref_src_t              speed_ref_src,
  output ssr_pkg::ssr_run_t                  run_status,
  output logic                               three_wire_mode
);
  import ssr_pkg::*;

  localparam int HC = (HOLD_CYC < 1) ? 1 : HOLD_CYC;
  localparam int CW = $clog2(HC + 1);
  localparam logic [CW-1:0] HOLD_MAX = CW'(HC);

  // two-stage synchronizers: first stage read only by second
  localparam int NS = NUM_PROG + 2;
  logic [NS-1:0] meta_r;
  logic [NS-1:0] sync_r;
  logic [NS-1:0] meta_nxt;
  logic [NS-1:0] sync_nxt;

  always_comb begin
    meta_nxt = rst_n ? {reverse_run_input, forward_run_input, prog_input} : '0;
    sync_nxt = rst_n ? meta_r : '0;
  end

  always_ff @(posedge clock) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end

  logic                fwd_s;
  logic                rev_s;
  logic [NUM_PROG-1:0] prog_s;
  assign fwd_s  = sync_r[NUM_PROG];
  assign rev_s  = sync_r[NUM_PROG+1];
  assign prog_s = sync_r[NUM_PROG-1:0];

  // per-terminal function decode, terminal k+3 owns parameter k
  logic [NUM_PROG-1:0] is_s1;
  logic [NUM_PROG-1:0] is_s2;
  logic [NUM_PROG-1:0] is_s3;
  logic [NUM_PROG-1:0] is_jog;
  logic [NUM_PROG-1:0] is_dir;
  genvar g;
  generate
    for (g = 0; g < NUM_PROG; g++) begin : g_term
      logic [7:0] fn;
      assign fn        = input_function_params[g*8 +: 8];
      assign is_s1[g]  = fn == FN_STEP1;
      assign is_s2[g]  = fn == FN_STEP2;
      assign is_s3[g]  = fn == FN_STEP3;
      assign is_jog[g] = fn == FN_JOG;
      assign is_dir[g] = fn == FN_THREE_WIRE;
    end
  endgenerate

  logic b1;
  logic b2;
  logic b3;
  logic jg;
  logic dir_in;
  logic three_wire;
  assign b1         = |(is_s1 & prog_s);
  assign b2         = |(is_s2 & prog_s);
  assign b3         = |(is_s3 & prog_s);
  assign jg         = |(is_jog & prog_s);
  // initialize for three-wire forces terminal 3 as direction input
  assign three_wire = initialize_three_wire | (|is_dir);
  assign dir_in     = initialize_three_wire ? prog_s[0] : |(is_dir & prog_s);

  // speed reference selection
  logic [SPD_W-1:0] spd_r;
  logic [SPD_W-1:0] spd_nxt;
  logic [4:0]       idx_r;
  logic [4:0]       idx_nxt;
  ssr_ref_src_t     src_r;
  ssr_ref_src_t     src_nxt;

  always_comb begin
    idx_nxt = {2'h0, b3, b2, b1};
    src_nxt = SSR_SRC_PRESET;
    if (jg) begin
      idx_nxt = JOG_INDEX;
    end else if (idx_nxt == 5'h00) begin
      if (speed_source_select == SPD_ANALOG) begin
        src_nxt = SSR_SRC_AN1;
      end
    end else if (idx_nxt == 5'h01) begin
      if (second_analog_function == AN_AUX1 || third_analog_function == AN_AUX1) begin
        src_nxt = (second_analog_function == AN_AUX1) ? SSR_SRC_AN2 : SSR_SRC_AN3;
      end
    end else if (idx_nxt == 5'h02) begin
      if (third_analog_function == AN_AUX2) begin
        src_nxt = SSR_SRC_AN3;
      end
    end
    case (src_nxt)
      SSR_SRC_AN1: spd_nxt = analog_in_first;
      SSR_SRC_AN2: spd_nxt = analog_in_second;
      SSR_SRC_AN3: spd_nxt = analog_in_third;
      default:     spd_nxt = jg ? jog_preset_speed : preset_speeds[idx_nxt[3:0]*SPD_W +: SPD_W];
    endcase
    if (!rst_n) begin
      idx_nxt = IDX_RESET;
      src_nxt = SSR_SRC_PRESET;
      spd_nxt = '0;
    end
  end

  always_ff @(posedge clock) begin
    idx_r <= idx_nxt;
    src_r <= src_nxt;
    spd_r <= spd_nxt;
  end

  // run command handling
  logic            run_r;
  logic            run_nxt;
  logic            rev_dir_r;
  logic            rev_dir_nxt;
  logic            jog_run_r;
  logic            jog_run_nxt;
  logic [1:0]      rsrc_r;
  logic [1:0]      rsrc_nxt;
  logic            tw_r;
  logic            tw_nxt;
  logic [CW-1:0]   hold_r;
  logic [CW-1:0]   hold_nxt;
  ssr_cmd_t        ext;

  always_comb begin
    case (rsrc_r)
      RUN_OPERATOR: ext = operator_cmd;
      RUN_SERIAL:   ext = serial_cmd;
      default:      ext = option_cmd;
    endcase
  end

  always_comb begin
    run_nxt     = run_r;
    rev_dir_nxt = rev_dir_r;
    jog_run_nxt = 1'b0;
    hold_nxt    = hold_r;
    tw_nxt      = three_wire;
    // source may only change while stopped
    rsrc_nxt    = run_r ? rsrc_r : run_source_select;
    if (rsrc_r == RUN_TERMINALS) begin
      if (!three_wire) begin
        hold_nxt = '0;
        if (fwd_s && !rev_s) begin
          run_nxt     = 1'b1;
          rev_dir_nxt = 1'b0;
        end else if (rev_s && !fwd_s) begin
          run_nxt     = 1'b1;
          rev_dir_nxt = 1'b1;
        end else begin
          run_nxt = 1'b0;
        end
        jog_run_nxt = run_nxt & jg;
      end else begin
        // pulse shorter than hold time is ignored, filters contact bounce
        hold_nxt = fwd_s ? ((hold_r == HOLD_MAX) ? hold_r : hold_r + CW'(1)) : '0;
        if (!rev_s) begin
          run_nxt = 1'b0;
        end else if (hold_nxt == HOLD_MAX) begin
          run_nxt = 1'b1;
        end
        rev_dir_nxt = dir_in;
        jog_run_nxt = run_nxt & jg;
      end
    end else begin
      hold_nxt = '0;
      if (ext.stop) begin
        run_nxt = 1'b0;
      end else if (ext.run || ext.jog) begin
        run_nxt = 1'b1;
      end
      rev_dir_nxt = ext.reverse;
      jog_run_nxt = run_nxt & ext.jog;
    end
    if (!rst_n) begin
      run_nxt     = 1'b0;
      rev_dir_nxt = 1'b0;
      jog_run_nxt = 1'b0;
      hold_nxt    = '0;
      rsrc_nxt    = RUN_SRC_RESET;
      tw_nxt      = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    run_r     <= run_nxt;
    rev_dir_r <= rev_dir_nxt;
    jog_run_r <= jog_run_nxt;
    hold_r    <= hold_nxt;
    rsrc_r    <= rsrc_nxt;
    tw_r      <= tw_nxt;
  end

  assign speed_ref       = spd_r;
  assign speed_index     = idx_r;
  assign speed_ref_src   = src_r;
  assign run_status      = '{running: run_r, reverse: rev_dir_r, jog: jog_run_r, source: rsrc_r};
  assign three_wire_mode = tw_r;

  // assertions
  property p_jog_prio;
    @(posedge clock) disable iff (!rst_n) jg |=> speed_index == JOG_INDEX;
  endproperty
  a_jog_prio: assert property (p_jog_prio) else $error("jog not given priority");
  property p_jog_speed;
    @(posedge clock) disable iff (!rst_n) jg |=> speed_ref == $past(jog_preset_speed);
  endproperty
  a_jog_speed: assert property (p_jog_speed) else $error("jog speed not used");
  property p_step_idx;
    @(posedge clock) disable iff (!rst_n) !jg |=> speed_index == {2'h0, $past(b3), $past(b2), $past(b1)};
  endproperty
  a_step_idx: assert property (p_step_idx) else $error("step index mismatch");
  property p_master;
    @(posedge clock) disable iff (!rst_n)
      (!jg && !b1 && !b2 && !b3 && speed_source_select == SPD_PRESET) |=> speed_ref_src == SSR_SRC_PRESET && speed_index == 5'h00;
  endproperty
  a_master: assert property (p_master) else $error("master preset not chosen");
  property p_aux1;
    @(posedge clock) disable iff (!rst_n)
      (!jg && b1 && !b2 && !b3 && second_analog_function == AN_AUX1) |=> speed_ref_src == SSR_SRC_AN2;
  endproperty
  a_aux1: assert property (p_aux1) else $error("auxiliary switch missed");
  property p_aux2;
    @(posedge clock) disable iff (!rst_n)
      (!jg && !b1 && b2 && !b3 && third_analog_function == AN_AUX2) |=> speed_ref_src == SSR_SRC_AN3;
  endproperty
  a_aux2: assert property (p_aux2) else $error("second auxiliary missed");
  property p_an1;
    @(posedge clock) disable iff (!rst_n)
      (!jg && !b1 && !b2 && !b3 && speed_source_select == SPD_ANALOG)
        |=> speed_ref_src == SSR_SRC_AN1 && speed_ref == $past(analog_in_first);
  endproperty
  a_an1: assert property (p_an1) else $error("first analog not used for step one");
  property p_src_frozen;
    @(posedge clock) disable iff (!rst_n) run_r |=> rsrc_r == $past(rsrc_r);
  endproperty
  a_src_frozen: assert property (p_src_frozen) else $error("run source changed while running");
  property p_two_wire;
    @(posedge clock) disable iff (!rst_n)
      (rsrc_r == RUN_TERMINALS && !three_wire && fwd_s && !rev_s) |=> run_status.running && !run_status.reverse;
  endproperty
  a_two_wire: assert property (p_two_wire) else $error("forward two-wire run missed");
  property p_two_rev;
    @(posedge clock) disable iff (!rst_n)
      (rsrc_r == RUN_TERMINALS && !three_wire && rev_s && !fwd_s) |=> run_status.running && run_status.reverse;
  endproperty
  a_two_rev: assert property (p_two_rev) else $error("reverse two-wire run missed");
  property p_stop3;
    @(posedge clock) disable iff (!rst_n) (rsrc_r == RUN_TERMINALS && three_wire && !rev_s) |=> !run_status.running;
  endproperty
  a_stop3: assert property (p_stop3) else $error("three-wire stop ignored");
  property p_short_pulse;
    @(posedge clock) disable iff (!rst_n)
      (three_wire && rsrc_r == RUN_TERMINALS && !run_r && hold_r < HOLD_MAX - CW'(1)) |=> !run_r;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("run latched before hold time");
  // direction follows the terminal continuously, no latch on the run edge
  property p_three_dir;
    @(posedge clock) disable iff (!rst_n) (rsrc_r == RUN_TERMINALS && three_wire) |=> run_status.reverse == $past(dir_in);
  endproperty
  a_three_dir: assert property (p_three_dir) else $error("three-wire direction not followed");
  property p_ext_stop;
    @(posedge clock) disable iff (!rst_n) (rsrc_r != RUN_TERMINALS && ext.stop) |=> !run_status.running;
  endproperty
  a_ext_stop: assert property (p_ext_stop) else $error("panel or link stop ignored");

  c_jog: cover property (@(posedge clock) disable iff (!rst_n) speed_index == JOG_INDEX);
  c_step8: cover property (@(posedge clock) disable iff (!rst_n) speed_index == 5'h07);
  c_latch3: cover property (@(posedge clock) disable iff (!rst_n) three_wire_mode && $rose(run_r));
  c_serial: cover property (@(posedge clock) disable iff (!rst_n) run_status.running && run_status.source == RUN_SERIAL);
  c_opt_jog: cover property (@(posedge clock) disable iff (!rst_n) run_status.jog && run_status.source == RUN_OPTION);
endmodule
`default_nettype wire

// >>> src/ssr_pkg.sv
/*
  package for the speed step and run select block: function codes, selector values,
  timing and the packed carriers shared by the design.
  assumes a single 25 MHz control clock and contact inputs that arrive asynchronously.
*/
// Functional notes
// - function codes 3,4,5,6 assign step/jog inputs
// - second analog at 2: bit1 swaps master/auxiliary
// - preset index is one plus binary step bits
// - all inputs off selects master: preset one, or first analog when analog source selected
// - steps 2,3 pick preset or auxiliary reference
// - jog select overrides every step combination
// - run source 0..3, default 1, frozen while running
// - source 0 takes operator panel commands
// - source 1 takes terminals, two-wire default
// - two-wire: forward runs while forward input on
// - two-wire: reverse runs while reverse input on
// - ten function params map terminals three to twelve
// - any function 0 selects three-wire, direction input
// - three-wire initialize makes input 3 direction
// - three-wire run held 50 ms then self-holds
// - seventeen speeds: sixteen presets plus jog; the three step bits reach only eight presets
`default_nettype none
package ssr_pkg;
  localparam int          CLK_HZ          = 25_000_000;
  localparam int          HOLD_MS         = 50;
  localparam int          HOLD_CYCLES     = (CLK_HZ / 1000) * HOLD_MS;
  localparam int          NUM_PROG        = 10;
  localparam int          FIRST_PROG_TERM = 3;
  localparam int          NUM_PRESETS     = 16;
  localparam int          SPEED_W         = 16;
  localparam logic [7:0]  FN_THREE_WIRE   = 8'h00;
  localparam logic [7:0]  FN_STEP1        = 8'h03;
  localparam logic [7:0]  FN_STEP2        = 8'h04;
  localparam logic [7:0]  FN_STEP3        = 8'h05;
  localparam logic [7:0]  FN_JOG          = 8'h06;
  localparam logic [7:0]  AN_AUX1         = 8'h02;
  localparam logic [7:0]  AN_AUX2         = 8'h03;
  localparam logic [7:0]  AN_UNUSED       = 8'h1F;
  localparam logic [0:0]  SPD_PRESET      = 1'h0;
  localparam logic [0:0]  SPD_ANALOG      = 1'h1;
  localparam logic [1:0]  RUN_OPERATOR    = 2'h0;
  localparam logic [1:0]  RUN_TERMINALS   = 2'h1;
  localparam logic [1:0]  RUN_SERIAL      = 2'h2;
  localparam logic [1:0]  RUN_OPTION      = 2'h3;
  localparam logic [1:0]  RUN_SRC_RESET   = RUN_TERMINALS;
  localparam logic [4:0]  JOG_INDEX       = 5'h10;
  localparam logic [4:0]  IDX_RESET       = 5'h00;

  typedef enum logic [1:0] {
    SSR_SRC_PRESET,
    SSR_SRC_AN1,
    SSR_SRC_AN2,
    SSR_SRC_AN3
  } ssr_ref_src_t;

  typedef struct packed {
    logic run;
    logic stop;
    logic jog;
    logic reverse;
  } ssr_cmd_t;

  typedef struct packed {
    logic       running;
    logic       reverse;
    logic       jog;
    logic [1:0] source;
  } ssr_run_t;
endpackage
`default_nettype wire

// >>> dv/ssr_contacts.sv
/*
  contact switch model: run contacts and the ten programmable contacts.
  assumes the bench moves contacts only through the tasks below.
*/
`default_nettype none
module ssr_contacts (
  input  wire logic  clock,
  output logic       fwd,
  output logic       rev,
  output logic [9:0] prog
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    fwd = 1'b0;
    rev = 1'b0;
    prog = 10'h000;
  end
  // contacts move just after an edge, so the synchronizer sees a clean level
  task automatic set(input logic f, input logic r, input logic [9:0] p);
    @(posedge clock) #1;
    fwd = f;
    rev = r;
    prog = p;
  endtask
  // run button held n cycles; a short hold is a refusal case on purpose
  task automatic press(input int n);
    @(posedge clock) #1;
    fwd = 1'b1;
    repeat (n) @(posedge clock);
    #1 fwd = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> dv/ssr_select_tb.sv
/*
  self-checking bench for ssr_select: step decode, analog swap, run sources.
  assumes ssr_pkg, ssr_select and ssr_contacts are compiled before it.
*/
`default_nettype none
module ssr_select_tb;
  import ssr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [79:0] FN_TWO   = {48'h1F1F1F1F1F1F, 32'h06050403};
  localparam logic [79:0] FN_THREE = {40'h1F1F1F1F1F, 8'h00, 32'h06050403};
  logic         clock;
  logic         rst_n;
  logic         init3;
  logic         fwd;
  logic         rev;
  logic [9:0]   prog;
  logic [79:0]  fn;
  logic [0:0]   spd_src;
  logic [1:0]   run_src;
  logic [7:0]   an2_fn;
  logic [7:0]   an3_fn;
  logic [255:0] presets;
  logic [15:0]  jog_spd;
  logic [15:0]  an1;
  logic [15:0]  an2;
  logic [15:0]  an3;
  ssr_cmd_t     op_cmd;
  ssr_cmd_t     ser_cmd;
  ssr_cmd_t     opt_cmd;
  logic         jog_want;
  logic [15:0]  speed_ref;
  logic [4:0]   speed_index;
  ssr_ref_src_t speed_ref_src;
  ssr_run_t     run_status;
  logic         three_wire_mode;
  logic [28:0]  exp_q[$];
  logic [28:0]  got;
  logic [28:0]  want;
  int           error_cnt;
  int           checks_done;
  int           cyc;
  integer       seed;
  event         ev_look;

  ssr_contacts i_sw (.clock(clock), .fwd(fwd), .rev(rev), .prog(prog));

  ssr_select #(.HOLD_CYC(8)) i_dut (
    .clock(clock), .rst_n(rst_n), .forward_run_input(fwd), .reverse_run_input(rev),
    .prog_input(prog), .input_function_params(fn), .initialize_three_wire(init3),
    .speed_source_select(spd_src), .run_source_select(run_src),
    .second_analog_function(an2_fn), .third_analog_function(an3_fn), .preset_speeds(presets),
    .jog_preset_speed(jog_spd), .analog_in_first(an1), .analog_in_second(an2),
    .analog_in_third(an3), .operator_cmd(op_cmd), .serial_cmd(ser_cmd), .option_cmd(opt_cmd),
    .speed_ref(speed_ref), .speed_index(speed_index), .speed_ref_src(speed_ref_src),
    .run_status(run_status), .three_wire_mode(three_wire_mode));

  assign got = {speed_ref, speed_index, speed_ref_src, run_status.running,
                run_status.reverse, run_status.source, three_wire_mode, run_status.jog};

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // outputs settle three edges after a contact change; five leaves margin
  task automatic expect_out(input logic [15:0] r, input logic [4:0] i, input logic [1:0] s,
                            input logic run, input logic rv, input logic [1:0] so, input logic tw);
    repeat (5) @(posedge clock);
    #1 exp_q.push_back({r, i, s, run, rv, so, tw, jog_want});
    -> ev_look;
  endtask

  task automatic ex_run(input logic run, input logic rv, input logic [1:0] so, input logic tw);
    expect_out(presets[15:0], 5'h00, SSR_SRC_PRESET, run, rv, so, tw);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(ev_look) begin
    want = exp_q.pop_front();
    checks_done++;
    if (got !== want) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  end

  // ceiling well above the roughly 225 cycles the sequence needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      results();
    end
  end

  initial begin
    seed = 32'hA773;
    rst_n = 1'b0;
    init3 = 1'b0;
    fn = FN_TWO;
    spd_src = SPD_PRESET;
    run_src = RUN_TERMINALS;
    an2_fn = AN_UNUSED;
    an3_fn = AN_UNUSED;
    op_cmd = '0;
    ser_cmd = '0;
    opt_cmd = '0;
    jog_want = 1'b0;
    for (int k = 0; k < 8; k++) presets[k*32+:32] = $random(seed);
    {jog_spd, an1} = $random(seed);
    {an2, an3} = $random(seed);
    repeat (5) @(posedge clock);
    #1 exp_q.push_back(29'h0000004);
    -> ev_look;
    rst_n = 1'b1;
    for (int k = 0; k < 8; k++) begin
      i_sw.set(1'b0, 1'b0, 10'(k));
      expect_out(presets[k*16+:16], 5'(k), SSR_SRC_PRESET, 1'b0, 1'b0, 2'h1, 1'b0);
    end
    for (int k = 0; k < 3; k++) begin
      i_sw.set(1'b0, 1'b0, {6'h00, 1'b1, 3'($random(seed))});
      expect_out(jog_spd, JOG_INDEX, SSR_SRC_PRESET, 1'b0, 1'b0, 2'h1, 1'b0);
    end
    spd_src = SPD_ANALOG;
    i_sw.set(1'b0, 1'b0, 10'h000);
    expect_out(an1, 5'h00, SSR_SRC_AN1, 1'b0, 1'b0, 2'h1, 1'b0);
    an2_fn = AN_AUX1;
    i_sw.set(1'b0, 1'b0, 10'h001);
    expect_out(an2, 5'h01, SSR_SRC_AN2, 1'b0, 1'b0, 2'h1, 1'b0);
    an3_fn = AN_AUX2;
    i_sw.set(1'b0, 1'b0, 10'h002);
    expect_out(an3, 5'h02, SSR_SRC_AN3, 1'b0, 1'b0, 2'h1, 1'b0);
    spd_src = SPD_PRESET;
    an2_fn = AN_UNUSED;
    an3_fn = AN_UNUSED;
    i_sw.set(1'b1, 1'b0, 10'h000);
    ex_run(1'b1, 1'b0, 2'h1, 1'b0);
    i_sw.set(1'b0, 1'b0, 10'h000);
    ex_run(1'b0, 1'b0, 2'h1, 1'b0);
    i_sw.set(1'b0, 1'b1, 10'h000);
    ex_run(1'b1, 1'b1, 2'h1, 1'b0);
    // both contacts stop the drive but leave the last direction standing
    i_sw.set(1'b1, 1'b1, 10'h000);
    ex_run(1'b0, 1'b1, 2'h1, 1'b0);
    i_sw.set(1'b1, 1'b0, 10'h000);
    ex_run(1'b1, 1'b0, 2'h1, 1'b0);
    run_src = RUN_OPERATOR;
    ex_run(1'b1, 1'b0, 2'h1, 1'b0);
    i_sw.set(1'b0, 1'b0, 10'h000);
    ex_run(1'b0, 1'b0, 2'h0, 1'b0);
    op_cmd.run = 1'b1;
    op_cmd.reverse = 1'b1;
    ex_run(1'b1, 1'b1, 2'h0, 1'b0);
    op_cmd.stop = 1'b1;
    ex_run(1'b0, 1'b1, 2'h0, 1'b0);
    op_cmd = '0;
    run_src = RUN_SERIAL;
    ser_cmd = '{run: 1'b1, stop: 1'b0, jog: 1'b0, reverse: 1'($random(seed))};
    ex_run(1'b1, ser_cmd.reverse, 2'h2, 1'b0);
    ser_cmd.stop = 1'b1;
    ex_run(1'b0, ser_cmd.reverse, 2'h2, 1'b0);
    run_src = RUN_OPTION;
    opt_cmd.jog = 1'b1;
    jog_want = 1'b1;
    ex_run(1'b1, 1'b0, 2'h3, 1'b0);
    jog_want = 1'b0;
    opt_cmd.stop = 1'b1;
    ex_run(1'b0, 1'b0, 2'h3, 1'b0);
    run_src = RUN_TERMINALS;
    ex_run(1'b0, 1'b0, 2'h1, 1'b0);
    fn = FN_THREE;
    i_sw.set(1'b0, 1'b1, 10'h000);
    ex_run(1'b0, 1'b0, 2'h1, 1'b1);
    i_sw.press(4);
    ex_run(1'b0, 1'b0, 2'h1, 1'b1);
    i_sw.press(14);
    ex_run(1'b1, 1'b0, 2'h1, 1'b1);
    i_sw.set(1'b0, 1'b1, 10'h010);
    ex_run(1'b1, 1'b1, 2'h1, 1'b1);
    i_sw.set(1'b0, 1'b0, 10'h000);
    ex_run(1'b0, 1'b0, 2'h1, 1'b1);
    fn = FN_TWO;
    i_sw.set(1'b0, 1'b1, 10'h000);
    init3 = 1'b1;
    ex_run(1'b0, 1'b0, 2'h1, 1'b1);
    rst_n = 1'b0;
    expect_out(16'h0000, 5'h00, SSR_SRC_PRESET, 1'b0, 1'b0, RUN_SRC_RESET, 1'b0);
    @(posedge clock);
    results();
  end
endmodule
`default_nettype wire
